// *** src/dcfft_pkg.sv ***
// Package for the strapped-mode FIFO: register map, mode encodings,
// carrier structs and the strap decoder.
// Assumes one clock; the strap inputs are static while reset is held.
package dcfft_pkg;

  localparam int DATA_W    = 18;
  localparam int DEF_DEPTH = 256;
  localparam int OFS_W     = 12;
  localparam int AXI_AW    = 8;

  // Register byte addresses
  localparam logic [AXI_AW-1:0] REG_MODE      = 8'h00;
  localparam logic [AXI_AW-1:0] REG_EMPTY_OFS = 8'h04;
  localparam logic [AXI_AW-1:0] REG_FULL_OFS  = 8'h08;
  localparam logic [AXI_AW-1:0] REG_STATUS    = 8'h0c;

  // Offset reset values
  localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 12'h01f;
  localparam logic [OFS_W-1:0] FULL_OFS_RST  = 12'h01f;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status register field positions
  localparam int ST_FULL_BIT  = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_AE_BIT    = 2;
  localparam int ST_AF_BIT    = 3;
  localparam int ST_HF_BIT    = 4;
  localparam int ST_CNT_LSB   = 16;

  typedef enum logic [1:0] {
    TIM_STD_SINGLE,
    TIM_STD_DOUBLE,
    TIM_FALL_THROUGH
  } dcfft_timing_type;

  typedef struct packed {
    logic first_load_n;
    logic read_expansion_in_n;
    logic write_expansion_in_n;
  } dcfft_strap_type;

  typedef struct packed {
    dcfft_timing_type timing;
    logic             sync_partial;
    logic             single_device;
  } dcfft_mode_type;

  typedef struct packed {
    logic              wen_n;
    logic [DATA_W-1:0] data;
  } dcfft_wr_type;

  typedef struct packed {
    logic full_flag_n;
    logic empty_flag_n;
    logic almost_empty_n;
    logic almost_full_n;
    logic half_full_n;
    logic read_expansion_out_n;
  } dcfft_flags_type;

  function automatic dcfft_mode_type dcfft_decode(input dcfft_strap_type s);
    dcfft_mode_type m;
    logic [2:0]     c;
    c = {s.first_load_n, s.read_expansion_in_n, s.write_expansion_in_n};
    m.timing        = TIM_STD_SINGLE;
    m.sync_partial  = 1'b0;
    m.single_device = 1'b1;
    case (c)
      3'h1, 3'h5: m.timing = TIM_FALL_THROUGH;
      3'h2, 3'h6: m.timing = TIM_STD_DOUBLE;
      default:    m.timing = TIM_STD_SINGLE;
    endcase
    case (c)
      3'h4, 3'h5, 3'h6: m.sync_partial = 1'b1;
      default:          m.sync_partial = 1'b0;
    endcase
    case (c)
      3'h3, 3'h7: m.single_device = 1'b0;
      default:    m.single_device = 1'b1;
    endcase
    return m;
  endfunction : dcfft_decode

endpackage : dcfft_pkg

// *** src/dcfft_fifo.sv ***
// Strap-configured 18-bit FIFO with standard or fall-through timing,
// single/double registered flags, partial flags, half-full/expansion outputs
// and an AXI4-Lite slave for the offsets and status.
// Assumes writer, reader and bus all run on aclk; straps static in reset.
`timescale 1ns/1ps

module dcfft_fifo
  import dcfft_pkg::*;
#(
  parameter int DEPTH = DEF_DEPTH
)(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire dcfft_strap_type       strap,
  input  wire dcfft_wr_type          wr,
  input  wire logic                  ren_n,
  input  wire logic                  oe_n,
  output logic [DATA_W-1:0]          read_data_bus,
  output logic                       read_data_oe,
  output dcfft_flags_type            flags,
  input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_AW-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  localparam int AW    = $clog2(DEPTH);
  localparam int CW    = AW + 1;
  localparam int THR_W = OFS_W + 2;
  localparam logic [CW-1:0]    MEM_FULL = CW'(DEPTH);
  localparam logic [AW-1:0]    LAST_LOC = AW'(DEPTH - 1);
  localparam logic [THR_W-1:0] HALF     = THR_W'(DEPTH / 2);

  // Storage and pointers
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [AW-1:0]     wptr_q, wptr_d, rptr_q, rptr_d;
  logic [CW-1:0]     cnt_q, cnt_d;
  logic              out_valid_q, out_valid_d;
  logic              mem_avail_q, mem_avail_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              oe_q, oe_d;
  dcfft_mode_type    mode_q, mode_d;
  dcfft_flags_type   flags_q, flags_d;
  logic [OFS_W-1:0]  empty_ofs_q, empty_ofs_d, full_ofs_q, full_ofs_d;

  logic              fall_through_mode, wr_ok, rd_mem, true_read;
  logic [THR_W-1:0]  tot, cap, ae_thr, af_thr;
  logic              ae_hit, af_hit;

  assign read_data_bus = rdata_q;
  assign read_data_oe  = oe_q;
  assign flags         = flags_q;

  always_comb
  begin
    fall_through_mode      = (mode_q.timing == TIM_FALL_THROUGH);
    wr_ok     = ~wr.wen_n & (cnt_q != MEM_FULL);
    true_read = fall_through_mode & ~ren_n & out_valid_q;
    if (fall_through_mode)
    begin
      // two-stage path to the output register
      rd_mem = mem_avail_q & (cnt_q != '0) & (~out_valid_q | true_read);
    end
    else
    begin
      // A standard read is gated by the registered empty flag, so a word
      // written into an empty memory is first seen one edge after the flag
      // rises; with one shared clock the skew-late case never arises.
      // read only with empty flag already high
      rd_mem = ~ren_n & flags_q.empty_flag_n & (cnt_q != '0);
    end
    wptr_d      = wr_ok ? wptr_q + 1'b1 : wptr_q;
    rptr_d      = rd_mem ? rptr_q + 1'b1 : rptr_q;
    cnt_d       = cnt_q + CW'(wr_ok) - CW'(rd_mem);
    mem_avail_d = (cnt_q != '0);
    // output-ready rises on a memory read (rd_mem), falls on a true read
    out_valid_d = fall_through_mode & (rd_mem | (out_valid_q & ~true_read));
    rdata_d     = rd_mem ? mem_q[rptr_q] : rdata_q;
    oe_d        = ~oe_n;
    // mode latched while reset is held
    mode_d      = mode_q;

    // capacity includes output register in fall-through
    tot    = THR_W'(cnt_d) + THR_W'(out_valid_d);
    cap    = THR_W'(DEPTH) + THR_W'(fall_through_mode);
    ae_thr = THR_W'(empty_ofs_q) + THR_W'(fall_through_mode);
    af_thr = cap - THR_W'(full_ofs_q);
    ae_hit = (tot <= ae_thr);
    af_hit = (tot >= af_thr);

    flags_d = flags_q;
    case (mode_q.timing)
      TIM_STD_SINGLE:
      begin
        flags_d.full_flag_n  = (cnt_d != MEM_FULL);
        flags_d.empty_flag_n = (cnt_d != '0);
      end
      TIM_STD_DOUBLE:
      begin
        // deassert one cycle after the freeing access
        flags_d.full_flag_n  = (cnt_d != MEM_FULL) & (cnt_q != MEM_FULL);
        flags_d.empty_flag_n = (cnt_d != '0) & (cnt_q != '0);
      end
      TIM_FALL_THROUGH:
      begin
        flags_d.full_flag_n  = (cnt_d == MEM_FULL) | (cnt_q == MEM_FULL);
        flags_d.empty_flag_n = ~out_valid_d;
      end
      default:
      begin
        flags_d.full_flag_n  = 1'b1;
        flags_d.empty_flag_n = 1'b0;
      end
    endcase

    if (mode_q.sync_partial)
    begin
      flags_d.almost_empty_n = ~ae_hit;
      flags_d.almost_full_n  = ~af_hit;
    end
    else
    begin
      // almost-empty low on read, high on write
      if (rd_mem && ae_hit)
        flags_d.almost_empty_n = 1'b0;
      else if (wr_ok && !ae_hit)
        flags_d.almost_empty_n = 1'b1;
      // almost-full low on write, high on read
      if (wr_ok && af_hit)
        flags_d.almost_full_n = 1'b0;
      else if (rd_mem && !af_hit)
        flags_d.almost_full_n = 1'b1;
    end

    if (mode_q.single_device)
    begin
      if (wr_ok && tot > HALF)
        flags_d.half_full_n = 1'b0;
      else if (rd_mem && tot <= HALF)
        flags_d.half_full_n = 1'b1;
      flags_d.read_expansion_out_n = 1'b1;
    end
    else
    begin
      // Pin becomes the write expansion pulse in a chain
      flags_d.half_full_n          = ~(wr_ok & (wptr_q == LAST_LOC));
      flags_d.read_expansion_out_n = ~(rd_mem & (rptr_q == LAST_LOC));
    end
  end

  always_ff @(posedge aclk)
  begin
    oe_q <= oe_d;
    if (wr_ok)
      mem_q[wptr_q] <= wr.data;
    if (!aresetn)
    begin
      mode_q      <= dcfft_decode(strap);
      wptr_q      <= '0;
      rptr_q      <= '0;
      cnt_q       <= '0;
      out_valid_q <= 1'b0;
      mem_avail_q <= 1'b0;
      rdata_q     <= '0;
      flags_q.full_flag_n          <= 1'b1;
      flags_q.empty_flag_n         <= (dcfft_decode(strap).timing == TIM_FALL_THROUGH);
      flags_q.almost_empty_n       <= 1'b0;
      flags_q.almost_full_n        <= 1'b1;
      flags_q.half_full_n          <= 1'b1;
      flags_q.read_expansion_out_n <= 1'b1;
    end
    else
    begin
      mode_q      <= mode_d;
      wptr_q      <= wptr_d;
      rptr_q      <= rptr_d;
      cnt_q       <= cnt_d;
      out_valid_q <= out_valid_d;
      mem_avail_q <= mem_avail_d;
      rdata_q     <= rdata_d;
      flags_q     <= flags_d;
    end
  end

  // AXI4-Lite slave
  // Write address and data are held independently; the response is issued
  // one edge after both are held, and the readies stay low until the master
  // takes it, so at most one write is under way. Reads answer on the same edge
  // that takes the address and hold the data until rready.
  logic                aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [AXI_AW-1:0]   aw_addr_q, aw_addr_d;
  logic [31:0]         w_data_q, w_data_d;
  logic [3:0]          w_strb_q, w_strb_d;
  logic                awready_q, awready_d, wready_q, wready_d;
  logic                bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]         axi_rdata_q, axi_rdata_d;

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = axi_rdata_q;

  always_comb
  begin
    aw_hold_d   = aw_hold_q | (s_axi_awvalid & awready_q);
    aw_addr_d   = (s_axi_awvalid & awready_q) ? s_axi_awaddr : aw_addr_q;
    w_hold_d    = w_hold_q | (s_axi_wvalid & wready_q);
    w_data_d    = (s_axi_wvalid & wready_q) ? s_axi_wdata : w_data_q;
    w_strb_d    = (s_axi_wvalid & wready_q) ? s_axi_wstrb : w_strb_q;
    bvalid_d    = bvalid_q & ~s_axi_bready;
    bresp_d     = bresp_q;
    empty_ofs_d = empty_ofs_q;
    full_ofs_d  = full_ofs_q;
    if (aw_hold_q && w_hold_q && !bvalid_q)
    begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (aw_addr_q)
        REG_EMPTY_OFS:
        begin
          if (w_strb_q[0]) empty_ofs_d[7:0]       = w_data_q[7:0];
          if (w_strb_q[1]) empty_ofs_d[OFS_W-1:8] = w_data_q[OFS_W-1:8];
        end
        REG_FULL_OFS:
        begin
          if (w_strb_q[0]) full_ofs_d[7:0]       = w_data_q[7:0];
          if (w_strb_q[1]) full_ofs_d[OFS_W-1:8] = w_data_q[OFS_W-1:8];
        end
        REG_MODE, REG_STATUS: bresp_d = RESP_OKAY;
        default:              bresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = ~aw_hold_d & ~bvalid_d;
    wready_d  = ~w_hold_d & ~bvalid_d;

    rvalid_d    = rvalid_q & ~s_axi_rready;
    rresp_d     = rresp_q;
    axi_rdata_d = axi_rdata_q;
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d    = 1'b1;
      rresp_d     = RESP_OKAY;
      axi_rdata_d = '0;
      case (s_axi_araddr)
        REG_MODE:      axi_rdata_d[3:0] = {mode_q.single_device, mode_q.sync_partial,
                                           mode_q.timing};
        REG_EMPTY_OFS: axi_rdata_d[OFS_W-1:0] = empty_ofs_q;
        REG_FULL_OFS:  axi_rdata_d[OFS_W-1:0] = full_ofs_q;
        REG_STATUS:
        begin
          axi_rdata_d[ST_FULL_BIT]  = flags_q.full_flag_n;
          axi_rdata_d[ST_EMPTY_BIT] = flags_q.empty_flag_n;
          axi_rdata_d[ST_AE_BIT]    = flags_q.almost_empty_n;
          axi_rdata_d[ST_AF_BIT]    = flags_q.almost_full_n;
          axi_rdata_d[ST_HF_BIT]    = flags_q.half_full_n;
          axi_rdata_d[ST_CNT_LSB +: CW] = cnt_q;
        end
        default:       rresp_d = RESP_SLVERR;
      endcase
    end
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q   <= 1'b0;
      w_hold_q    <= 1'b0;
      aw_addr_q   <= '0;
      w_data_q    <= '0;
      w_strb_q    <= '0;
      awready_q   <= 1'b0;
      wready_q    <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= RESP_OKAY;
      arready_q   <= 1'b0;
      rvalid_q    <= 1'b0;
      rresp_q     <= RESP_OKAY;
      axi_rdata_q <= '0;
      empty_ofs_q <= EMPTY_OFS_RST;
      full_ofs_q  <= FULL_OFS_RST;
    end
    else
    begin
      aw_hold_q   <= aw_hold_d;
      w_hold_q    <= w_hold_d;
      aw_addr_q   <= aw_addr_d;
      w_data_q    <= w_data_d;
      w_strb_q    <= w_strb_d;
      awready_q   <= awready_d;
      wready_q    <= wready_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      arready_q   <= arready_d;
      rvalid_q    <= rvalid_d;
      rresp_q     <= rresp_d;
      axi_rdata_q <= axi_rdata_d;
      empty_ofs_q <= empty_ofs_d;
      full_ofs_q  <= full_ofs_d;
    end
  end

endmodule : dcfft_fifo

// *** verification/dcfft_fifo_props.sv ***
// Checker of the strapped FIFO read port and flag timing.
// Bound to dcfft_fifo on one aclk; straps are latched while reset is low.
`timescale 1ns/1ps

module dcfft_fifo_props
  import dcfft_pkg::*;
#(
  parameter int DEPTH = DEF_DEPTH
)(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire dcfft_strap_type   strap,
  input wire dcfft_wr_type      wr,
  input wire logic              ren_n,
  input wire logic              oe_n,
  input wire logic [DATA_W-1:0] read_data_bus,
  input wire logic              read_data_oe,
  input wire dcfft_flags_type   flags
);
  logic [2:0] code_q, code_d;
  logic       ft, dbl, sgl, asy;

  always_comb
  begin
    code_d = aresetn ? code_q : strap;
    ft = code_q inside {3'h1, 3'h5};
    dbl = code_q inside {3'h2, 3'h6};
    sgl = !ft && !dbl;
    asy = !(code_q inside {3'h4, 3'h5, 3'h6});
  end

  always_ff @(posedge aclk)
  begin
    code_q <= code_d;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_oe_follow:
    assert property (1'b1 |=> read_data_oe == !$past(oe_n))
    else $error("output enable does not follow oe_n");
  a_full_hold:
    assert property (sgl && !flags.full_flag_n && ren_n |=> !flags.full_flag_n)
    else $error("full flag released without a read");
  a_empty_hold:
    assert property (sgl && !flags.empty_flag_n && wr.wen_n
      |=> !flags.empty_flag_n && $stable(read_data_bus)) else $error("read taken while empty");
  a_ft_hold:
    assert property (ft && !flags.empty_flag_n && ren_n
      |=> !flags.empty_flag_n && $stable(read_data_bus)) else $error("ready lost without read");
  a_ft_first:
    assert property (ft && flags.empty_flag_n && !flags.full_flag_n && !wr.wen_n
      |-> ##3 !flags.empty_flag_n) else $error("first word did not fall through");
  a_ir_reset:
    assert property (ft && $rose(aresetn) |=> !flags.full_flag_n)
    else $error("input ready not low after reset");
  a_full_double:
    assert property (dbl && !flags.full_flag_n && !ren_n && $past(ren_n) && wr.wen_n
      |=> !flags.full_flag_n ##1 flags.full_flag_n) else $error("double full flag timing");
  a_ae_async:
    assert property (asy && $fell(flags.almost_empty_n) |-> !$past(ren_n))
    else $error("almost empty set without a read");
  a_af_async:
    assert property (asy && $fell(flags.almost_full_n) |-> !$past(wr.wen_n))
    else $error("almost full set without a write");
  a_hf_write:
    assert property ($fell(flags.half_full_n) |-> !$past(wr.wen_n))
    else $error("half full set without a write");

  c_full: cover property (sgl && !flags.full_flag_n);
  c_ft_read: cover property (ft && !flags.empty_flag_n && !ren_n);
  c_dbl_read: cover property (dbl && !flags.full_flag_n && !ren_n);
endmodule : dcfft_fifo_props

bind dcfft_fifo dcfft_fifo_props #(.DEPTH(DEPTH)) u_props (.aclk(aclk), .aresetn(aresetn),
  .strap(strap), .wr(wr), .ren_n(ren_n), .oe_n(oe_n), .read_data_bus(read_data_bus),
  .read_data_oe(read_data_oe), .flags(flags));

// *** verification/dcfft_peer.sv ***
// Writer and reader logic facing the FIFO.
// Bench steps it by go levels; idle write data shows the inverse of the last word.
`timescale 1ns/1ps

module dcfft_peer
  import dcfft_pkg::*;
(
  input wire logic              aclk,
  input wire logic              wr_go,
  input wire logic [DATA_W-1:0] wr_word,
  input wire logic              rd_go,
  output dcfft_wr_type          wr,
  output logic                  ren_n
);
  logic [DATA_W-1:0] last_q = '0;

  always_ff @(posedge aclk)
  begin
    if (wr_go)
      last_q <= wr_word;
  end

  always_comb
  begin
    wr.wen_n = !wr_go;
    wr.data = wr_go ? wr_word : ~last_q;
    ren_n = !rd_go;
  end
endmodule : dcfft_peer

// *** verification/testbench.sv ***
// Self-checking bench: strap modes, flags, data order and registers of dcfft_fifo.
// One 100 MHz aclk; FIFO traffic goes through dcfft_peer.
`timescale 1ns/1ps

module testbench;
  import dcfft_pkg::*;
  localparam int D = 4;
  logic aclk = 1'b0, aresetn = 1'b0, oe_n = 1'b0, wr_go = 1'b0, rd_go = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_v;
  logic [DATA_W-1:0] wr_word = '0, read_data_bus;
  logic [1:0] bresp, rresp, rsp;
  logic ren_n, read_data_oe, awready, wready, bvalid, arready, rvalid;
  dcfft_strap_type strap = '0;
  dcfft_wr_type wr;
  dcfft_flags_type flags;
  int num_errors = 0, tests_run = 0, cyc = 0, wxo_cnt = 0, rxo_cnt = 0;

  dcfft_peer peer (.aclk(aclk), .wr_go(wr_go), .wr_word(wr_word), .rd_go(rd_go), .wr(wr),
    .ren_n(ren_n));
  dcfft_fifo #(.DEPTH(D)) dut (.aclk(aclk), .aresetn(aresetn), .strap(strap), .wr(wr),
    .ren_n(ren_n), .oe_n(oe_n), .read_data_bus(read_data_bus), .read_data_oe(read_data_oe),
    .flags(flags), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (!flags.half_full_n) wxo_cnt++;
    if (!flags.read_expansion_out_n) rxo_cnt++;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic [2:0] code);
    strap <= code;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
  endtask : do_reset

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic push(input int n, input logic [DATA_W-1:0] b);
    for (int i = 0; i < n; i++)
    begin
      wr_go <= 1'b1;
      wr_word <= b + DATA_W'(i);
      @(posedge aclk);
    end
    wr_go <= 1'b0;
  endtask : push

  task automatic pop(input int n, input logic [DATA_W-1:0] b);
    for (int i = 0; i < n; i++)
    begin
      rd_go <= 1'b1;
      @(posedge aclk);
      #1;
      chk(read_data_bus, b + DATA_W'(i));
    end
    rd_go <= 1'b0;
  endtask : pop

  task automatic t_modes();
    logic [3:0] e;
    for (int c = 0; c < 8; c++)
    begin
      do_reset(3'(c));
      strap <= ~3'(c);
      e[1:0] = (c == 1 || c == 5) ? 2'h2 : (c == 2 || c == 6) ? 2'h1 : 2'h0;
      e[2] = (c >= 4 && c <= 6);
      e[3] = !(c == 3 || c == 7);
      axi_rd(REG_MODE);
      chk(rd_v, {28'h0, e});
    end
  endtask : t_modes

  task automatic t_std();
    do_reset(3'h0);
    chk({read_data_oe, read_data_bus}, {1'b1, 18'h0});
    axi_wr(REG_EMPTY_OFS, 32'h1);
    axi_wr(REG_FULL_OFS, 32'h1);
    chk(rsp, RESP_OKAY);
    axi_rd(8'h10);
    chk(rsp, RESP_SLVERR);
    push(D + 1, 18'h100);
    #1;
    chk(flags, 6'h19);
    axi_rd(REG_STATUS);
    chk(rd_v[31:16], 16'(D));
    pop(1, 18'h100);
    chk(flags.full_flag_n, 1'b1);
    pop(3, 18'h101);
    chk(flags, 6'h27);
    rd_go <= 1'b1;
    @(posedge aclk);
    rd_go <= 1'b0;
    oe_n <= 1'b1;
    #1;
    chk(read_data_bus, 18'h103);
    @(posedge aclk);
    #1;
    chk(read_data_oe, 1'b0);
    oe_n <= 1'b0;
  endtask : t_std

  task automatic t_dbl();
    do_reset(3'h2);
    push(D, 18'h10);
    repeat (2) @(posedge aclk);
    #1;
    chk(flags.full_flag_n, 1'b0);
    pop(1, 18'h10);
    chk(flags.full_flag_n, 1'b0);
    @(posedge aclk);
    #1;
    chk(flags.full_flag_n, 1'b1);
  endtask : t_dbl

  task automatic t_ft();
    do_reset(3'h5);
    chk(flags.full_flag_n, 1'b0);
    push(1, 18'h200);
    @(posedge aclk);
    #1;
    chk(flags.empty_flag_n, 1'b1);
    @(posedge aclk);
    #1;
    chk({flags.empty_flag_n, read_data_bus}, {1'b0, 18'h200});
    repeat (3) @(posedge aclk);
    pop(1, 18'h200);
    chk(flags.empty_flag_n, 1'b1);
    push(D + 2, 18'h300);
    repeat (3) @(posedge aclk);
    #1;
    chk({flags.full_flag_n, read_data_bus}, {1'b1, 18'h300});
    pop(1, 18'h301);
    chk(flags.full_flag_n, 1'b1);
    @(posedge aclk);
    #1;
    chk(flags.full_flag_n, 1'b0);
    pop(3, 18'h302);
    pop(1, 18'h304);
    chk({flags.empty_flag_n, read_data_bus}, {1'b1, 18'h304});
  endtask : t_ft

  task automatic t_chain();
    do_reset(3'h3);
    wxo_cnt = 0;
    rxo_cnt = 0;
    push(D, 18'h40);
    @(posedge aclk);
    pop(D, 18'h40);
    repeat (2) @(posedge aclk);
    chk(rxo_cnt, 1);
    chk(wxo_cnt, 1);
  endtask : t_chain

  initial
  begin
    t_modes();
    t_std();
    t_dbl();
    t_ft();
    t_chain();
    test_done();
  end
endmodule : testbench
